// file: hw/abu_cfg.svh
/*
 * constants of the address breakpoint unit: offsets, fields, resets.
 * assumes an 8-bit register port with a 16-bit byte address.
 */
`ifndef ABU_CFG_SVH
`define ABU_CFG_SVH
`define ABU_OFS_STATUS 16'hFE00
`define ABU_OFS_FLAG_CTRL 16'hFE03
`define ABU_OFS_ADDR_HIGH 16'hFE0C
`define ABU_OFS_ADDR_LOW 16'hFE0D
`define ABU_OFS_CONTROL 16'hFE0E
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_SW_EXIT 1
`define ABU_BIT_CLR_EN 7
`define ABU_RST_BYTE 8'h00
`define ABU_ZERO_BYTE 8'h00
`endif

// file: hw/abu_pkg.sv
/*
 * types shared by the address breakpoint unit.
 * assumes nothing beyond a sv compiler.
 */
package abu_pkg;
    typedef enum logic [1:0] {
        ABU_IDLE,
        ABU_PENDING,
        ABU_IN_BREAK
    } abu_state_t;
    typedef logic [7:0] abu_byte_t;
endpackage

// file: hw/abu_byte_reg.sv
/*
 * one 8-bit read/write register with write strobe and zero reset.
 * assumes single clock, asynchronous active-low reset.
 */
`timescale 1ns/10ps
`include "abu_cfg.svh"
module abu_byte_reg
    import abu_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wr_in,
    input wire abu_byte_t data_in,
    output abu_byte_t value_out
);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            value_out <= `ABU_RST_BYTE;
        end else if (wr_in) begin
            value_out <= data_in;
        end
    end
endmodule

// file: hw/abu_compare.sv
/*
 * 16-bit address comparator for cpu fetch cycles.
 * assumes fetch qualifier and address are valid in the same cycle.
 */
`timescale 1ns/10ps
module abu_compare (
    input wire logic [15:0] addr_in,
    input wire logic [15:0] ref_in,
    input wire logic fetch_in,
    input wire logic enable_in,
    output logic match_out
);
    // only program-counter fetches count, so data traffic cannot break
    assign match_out = enable_in && fetch_in && (addr_in == ref_in);
endmodule

// file: hw/abu_top.sv
/*
 * address breakpoint unit: compare registers, break control, status flags.
 * assumes the cpu core drives a fetch qualifier, instruction-boundary,
 * return-from-interrupt and low-power indications, all synchronous to clk_in.
 */
`timescale 1ns/10ps
`include "abu_cfg.svh"
module abu_top
    import abu_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [15:0] cpu_addr_in,
    input wire logic cpu_fetch_in,
    input wire logic cpu_insn_end_in,
    input wire logic cpu_return_from_interrupt_in,
    input wire logic cpu_low_power_in,
    output logic break_request_out,
    output logic break_in_progress_out,
    output logic watchdog_disable_out,
    output logic status_clear_allow_out
);
    // -----------------------------------------------------------------
    // register port
    // -----------------------------------------------------------------
    abu_byte_t addr_high;
    abu_byte_t addr_low;
    logic wr_high;
    logic wr_low;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_flag;
    logic enable_q;
    logic active_q;
    logic sw_exit_q;
    logic clr_en_q;
    logic match;
    abu_state_t state_q;

    assign wr_high = reg_wr_in && (reg_addr_in == `ABU_OFS_ADDR_HIGH);
    assign wr_low = reg_wr_in && (reg_addr_in == `ABU_OFS_ADDR_LOW);
    assign wr_ctrl = reg_wr_in && (reg_addr_in == `ABU_OFS_CONTROL);
    assign wr_stat = reg_wr_in && (reg_addr_in == `ABU_OFS_STATUS);
    assign wr_flag = reg_wr_in && (reg_addr_in == `ABU_OFS_FLAG_CTRL);

    abu_byte_reg u_high (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_in(wr_high),
        .data_in(reg_wdata_in),
        .value_out(addr_high)
    );

    abu_byte_reg u_low (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_in(wr_low),
        .data_in(reg_wdata_in),
        .value_out(addr_low)
    );

    abu_compare u_cmp (
        .addr_in(cpu_addr_in),
        .ref_in({addr_high, addr_low}),
        .fetch_in(cpu_fetch_in),
        .enable_in(enable_q),
        .match_out(match)
    );

    // reads answer in every state, including during a break
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= `ABU_ZERO_BYTE;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `ABU_OFS_ADDR_HIGH: reg_rdata_out <= addr_high;
                `ABU_OFS_ADDR_LOW: reg_rdata_out <= addr_low;
                `ABU_OFS_CONTROL: reg_rdata_out <= {enable_q, active_q, 6'h00};
                `ABU_OFS_STATUS: reg_rdata_out <= {6'h00, sw_exit_q, 1'h0};
                `ABU_OFS_FLAG_CTRL: reg_rdata_out <= {clr_en_q, 7'h00};
                default: reg_rdata_out <= `ABU_ZERO_BYTE;
            endcase
        end else begin
            reg_rdata_out <= `ABU_ZERO_BYTE;
        end
    end

    // -----------------------------------------------------------------
    // control and flag registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_q <= 1'b0;
        end else if (wr_ctrl) begin
            enable_q <= reg_wdata_in[`ABU_BIT_ENABLE];
        end
    end

    // a match in the same cycle as a clearing write wins, so no break is lost
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            active_q <= 1'b0;
        end else if (match) begin
            active_q <= 1'b1;
        end else if (wr_ctrl) begin
            active_q <= reg_wdata_in[`ABU_BIT_ACTIVE];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clr_en_q <= 1'b0;
        end else if (wr_flag) begin
            clr_en_q <= reg_wdata_in[`ABU_BIT_CLR_EN];
        end
    end

    // set on wake-by-break; writing one leaves it alone
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sw_exit_q <= 1'b0;
        end else if (break_request_out && cpu_low_power_in) begin
            sw_exit_q <= 1'b1;
        end else if (wr_stat && !reg_wdata_in[`ABU_BIT_SW_EXIT]) begin
            sw_exit_q <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // break sequencing
    // -----------------------------------------------------------------
    // the cpu takes the request at an instruction boundary or in low power, and
    // leaves on return-from-interrupt; this unit only tracks those moments
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ABU_IDLE;
        end else begin
            case (state_q)
                ABU_IDLE: begin
                    if (active_q && !cpu_insn_end_in) begin
                        state_q <= ABU_PENDING;
                    end else if (active_q) begin
                        state_q <= ABU_IN_BREAK;
                    end
                end
                ABU_PENDING: begin
                    if (cpu_insn_end_in || cpu_low_power_in) begin
                        state_q <= ABU_IN_BREAK;
                    end
                end
                ABU_IN_BREAK: begin
                    if (cpu_return_from_interrupt_in) begin
                        state_q <= ABU_IDLE;
                    end
                end
                default: state_q <= ABU_IDLE;
            endcase
        end
    end

    assign break_request_out = active_q && (state_q != ABU_IN_BREAK);
    assign break_in_progress_out = (state_q == ABU_IN_BREAK);
    assign watchdog_disable_out = (state_q == ABU_IN_BREAK);
    assign status_clear_allow_out = (state_q != ABU_IN_BREAK) || clr_en_q;

    // -----------------------------------------------------------------
    // register checks
    // -----------------------------------------------------------------
    // each compare byte moves only on its own strobe
    a_high_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_high
            |=> addr_high == $past(reg_wdata_in))
        else $error("high compare byte not written");

    a_low_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_low
            |=> addr_low == $past(reg_wdata_in))
        else $error("low compare byte not written");

    a_high_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !wr_high
            |=> $stable(addr_high))
        else $error("high compare byte changed without write");

    a_low_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !wr_low
            |=> $stable(addr_low))
        else $error("low compare byte changed without write");

    a_high_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == `ABU_OFS_ADDR_HIGH)
            |=> reg_rdata_out == $past(addr_high))
        else $error("high compare byte read wrong");

    a_low_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == `ABU_OFS_ADDR_LOW)
            |=> reg_rdata_out == $past(addr_low))
        else $error("low compare byte read wrong");

    a_ctrl_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == `ABU_OFS_CONTROL)
            |=> reg_rdata_out == {$past(enable_q), $past(active_q), 6'h00})
        else $error("control read wrong");

    a_status_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == `ABU_OFS_STATUS)
            |=> reg_rdata_out == {6'h00, $past(sw_exit_q), 1'b0})
        else $error("status read wrong");

    a_flag_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == `ABU_OFS_FLAG_CTRL)
            |=> reg_rdata_out == {$past(clr_en_q), 7'h00})
        else $error("flag control read wrong");

    // the background program reads registers from inside the break routine
    a_read_in_break: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && reg_addr_in == `ABU_OFS_ADDR_LOW && break_in_progress_out)
            |=> reg_rdata_out == $past(addr_low))
        else $error("register not readable in break");

    // -----------------------------------------------------------------
    // flag checks
    // -----------------------------------------------------------------
    a_enable_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_ctrl
            |=> enable_q == $past(reg_wdata_in[`ABU_BIT_ENABLE]))
        else $error("break enable not written");

    a_enable_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !wr_ctrl
            |=> $stable(enable_q))
        else $error("break enable changed without write");

    a_enable_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!enable_q && !wr_ctrl && !active_q)
            |=> !active_q)
        else $error("break active without enable");

    a_match_sets_active: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        match
            |=> active_q)
        else $error("match did not set break active");

    // a match beats a clearing write, so only a quiet cycle may clear
    a_active_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_ctrl && !reg_wdata_in[`ABU_BIT_ACTIVE] && !match)
            |=> !active_q)
        else $error("break active not cleared");

    a_active_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!wr_ctrl && !match)
            |=> $stable(active_q))
        else $error("break active changed by itself");

    a_sw_trigger: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_ctrl && reg_wdata_in[`ABU_BIT_ACTIVE] && !active_q && state_q == ABU_IDLE)
            |=> break_request_out)
        else $error("software trigger gave no request");

    a_clr_en_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_flag
            |=> clr_en_q == $past(reg_wdata_in[`ABU_BIT_CLR_EN]))
        else $error("clear enable not written");

    a_clr_en_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !wr_flag
            |=> $stable(clr_en_q))
        else $error("clear enable changed without write");

    a_exit_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (break_request_out && cpu_low_power_in)
            |=> sw_exit_q)
        else $error("stop/wait flag not set");

    a_exit_no_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!sw_exit_q && !(break_request_out && cpu_low_power_in))
            |=> !sw_exit_q)
        else $error("stop/wait flag set without wake");

    // a wake in the same cycle outranks the clearing write
    a_exit_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_stat && !reg_wdata_in[`ABU_BIT_SW_EXIT] && !(break_request_out && cpu_low_power_in))
            |=> !sw_exit_q)
        else $error("stop/wait flag not cleared");

    a_exit_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (sw_exit_q && !(wr_stat && !reg_wdata_in[`ABU_BIT_SW_EXIT]))
            |=> sw_exit_q)
        else $error("stop/wait flag lost without clear");

    // -----------------------------------------------------------------
    // break sequencing checks
    // -----------------------------------------------------------------
    a_fetch_only: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !cpu_fetch_in
            |-> !match)
        else $error("non-fetch cycle matched");

    a_match_request: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (match && !break_in_progress_out && !cpu_insn_end_in && !cpu_low_power_in)
            |=> break_request_out)
        else $error("match gave no break request");

    // the cpu may not enter the break routine in mid-instruction
    a_pending_wait: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == ABU_PENDING && !cpu_insn_end_in && !cpu_low_power_in)
            |=> !break_in_progress_out)
        else $error("break entered before instruction end");

    a_boundary_entry: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (break_request_out && cpu_insn_end_in)
            |=> break_in_progress_out)
        else $error("no break at instruction end");

    a_watchdog_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == ABU_PENDING && cpu_insn_end_in)
            |=> watchdog_disable_out)
        else $error("watchdog not disabled in break");

    a_break_stays: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (break_in_progress_out && !cpu_return_from_interrupt_in)
            |=> break_in_progress_out)
        else $error("break ended without interrupt return");

    a_return_ends: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_q == ABU_IN_BREAK && cpu_return_from_interrupt_in)
            |=> !break_in_progress_out)
        else $error("interrupt return did not end break");

    a_watchdog_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !break_in_progress_out
            |-> !watchdog_disable_out)
        else $error("watchdog disabled outside break");

    a_clear_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (break_in_progress_out && !clr_en_q)
            |-> !status_clear_allow_out)
        else $error("status clear allowed in break");

    a_clear_allowed: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!break_in_progress_out || clr_en_q)
            |-> status_clear_allow_out)
        else $error("status clear refused");
endmodule

// file: bench/abu_cpu_model.sv
/* cpu core model facing the breakpoint unit: fetches, data cycles, break entry, return, sleep.
   assumes break_request_in comes from abu_top on the same clk_in. */
`timescale 1ns/10ps
module abu_cpu_model #(
    parameter logic MONITOR = 1'b0
) (
    input wire logic clk_in,
    input wire logic break_request_in,
    output logic [15:0] addr_out = 16'h0000,
    output logic fetch_out = 1'b0,
    output logic insn_end_out = 1'b0,
    output logic return_from_interrupt_out = 1'b0,
    output logic low_power_out = 1'b0
);
    logic take;
    // ----
    // one instruction: address cycle, then a non-fetch cycle ending it
    // ----
    task automatic insn(input logic [15:0] pc, input logic is_fetch);
        @(posedge clk_in);
        addr_out <= pc;
        fetch_out <= is_fetch;
        @(posedge clk_in);
        addr_out <= ~pc;
        fetch_out <= 1'b0;
        insn_end_out <= 1'b1;
        // sampled mid-cycle so the request is read before its edge acts
        @(negedge clk_in);
        take = break_request_in;
        @(posedge clk_in);
        insn_end_out <= 1'b0;
        if (take) begin
            addr_out <= MONITOR ? 16'hFEFC : 16'hFFFC;
            @(posedge clk_in);
            addr_out <= MONITOR ? 16'hFEFD : 16'hFFFD;
        end
    endtask
    task automatic return_from_interrupt();
        @(posedge clk_in);
        return_from_interrupt_out <= 1'b1;
        @(posedge clk_in);
        return_from_interrupt_out <= 1'b0;
    endtask
    task automatic nap(input int n);
        @(posedge clk_in);
        low_power_out <= 1'b1;
        repeat (n) @(posedge clk_in);
        low_power_out <= 1'b0;
    endtask
endmodule

// file: bench/abu_top_tb.sv
/* self-checking bench for abu_top: register port master, read queue, cpu model.
   assumes abu_top, abu_pkg and bench/abu_cpu_model are compiled first. */
`timescale 1ns/10ps
module abu_top_tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic rd_seen = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [15:0] cpu_addr_in, bp, seed = 16'h0050;
    logic cpu_fetch_in, cpu_insn_end_in, cpu_return_from_interrupt_in, cpu_low_power_in;
    logic break_request_out, break_in_progress_out, watchdog_disable_out, status_clear_allow_out;
    logic [7:0] exp_q[$];
    logic [15:0] ofs[6] = '{16'hFE00, 16'hFE03, 16'hFE0C, 16'hFE0D, 16'hFE0E, 16'hFE01};
    int num_errors = 0;
    int n_checks = 0;
    abu_top DUT (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .cpu_addr_in, .cpu_fetch_in, .cpu_insn_end_in,
        .cpu_return_from_interrupt_in, .cpu_low_power_in, .break_request_out,
        .break_in_progress_out, .watchdog_disable_out, .status_clear_allow_out);
    abu_cpu_model CPU (.clk_in, .break_request_in(break_request_out), .addr_out(cpu_addr_in),
        .fetch_out(cpu_fetch_in), .insn_end_out(cpu_insn_end_in),
        .return_from_interrupt_out(cpu_return_from_interrupt_in),
        .low_power_out(cpu_low_power_in));
    initial forever #4 clk_in = ~clk_in;
    // ----
    // helpers
    // ----
    function automatic logic [15:0] xs(input logic [15:0] s);
        s = s ^ (s << 7);
        s = s ^ (s >> 9);
        return s ^ (s << 8);
    endfunction
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
        n_checks++;
        if (got !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
    endtask
    // order: request, in progress, watchdog off, clear allowed
    task automatic outs(input logic [3:0] e);
        @(negedge clk_in);
        chk("outputs", {4'h0, e}, {4'h0, break_request_out, break_in_progress_out,
            watchdog_disable_out, status_clear_allow_out});
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ----
    // read data only stands in the cycle after the strobe
    // ----
    always @(posedge clk_in) rd_seen <= reg_rd_in;
    always @(negedge clk_in) if (rd_seen) chk("rdata", exp_q.pop_front(), reg_rdata_out);
    // whole sequence needs about 100 cycles
    initial begin
        repeat (2000) @(posedge clk_in);
        num_errors++;
        stop_test();
    end
    // ----
    // tests
    // ----
    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        outs(4'b0001);
        $display("reset values done");
        seed = xs(seed);
        bp = seed;
        wr(16'hFE0C, bp[15:8]);
        wr(16'hFE0D, bp[7:0]);
        foreach (ofs[i]) if (i < 2 || i == 5) wr(ofs[i], 8'hFF);
        wr(16'hFE0E, 8'hBF);
        rd(16'hFE0C, bp[15:8]);
        rd(16'hFE0D, bp[7:0]);
        rd(16'hFE03, 8'h80);
        rd(16'hFE00, 8'h00);
        rd(16'hFE01, 8'h00);
        rd(16'hFE0E, 8'h80);
        $display("register access done");
        wr(16'hFE0E, 8'h00);
        CPU.insn(bp, 1'b1);
        outs(4'b0001);
        wr(16'hFE0E, 8'h80);
        CPU.insn(bp, 1'b0);
        CPU.insn(bp ^ 16'h0100, 1'b1);
        CPU.insn(bp ^ 16'h0001, 1'b1);
        outs(4'b0001);
        CPU.insn(bp, 1'b1);
        outs(4'b0111);
        rd(16'hFE0E, 8'hC0);
        wr(16'hFE03, 8'h00);
        outs(4'b0110);
        wr(16'hFE0D, ~bp[7:0]);
        rd(16'hFE0D, ~bp[7:0]);
        wr(16'hFE0E, 8'h80);
        CPU.return_from_interrupt();
        outs(4'b0001);
        $display("address break done");
        wr(16'hFE0E, 8'h40);
        outs(4'b1001);
        CPU.nap(3);
        outs(4'b0110);
        rd(16'hFE00, 8'h02);
        wr(16'hFE00, 8'h00);
        rd(16'hFE00, 8'h00);
        wr(16'hFE0E, 8'h00);
        CPU.return_from_interrupt();
        outs(4'b0001);
        // trigger mid-instruction: entry waits for the instruction end
        wr(16'hFE0E, 8'h40);
        outs(4'b1001);
        CPU.insn(bp, 1'b0);
        outs(4'b0110);
        wr(16'hFE0E, 8'h00);
        CPU.return_from_interrupt();
        outs(4'b0001);
        $display("software break done");
        stop_test();
    end
endmodule
